// *** igen_cell.sv ***
// shared constants of the time code generator, and the per-output cell encoder
// assumes one clock domain; counters and the second mark come from the top module
`timescale 1ns/1ns

package igen_pkg;

	// ********************************************************************
	// frame geometry and pulse widths
	// ********************************************************************
	localparam int CELLS      = 100;
	localparam int CELL_MS    = 10;
	localparam int ZERO_MS    = 2;
	localparam int ONE_MS     = 5;
	localparam int MARK_MS    = 8;
	localparam int REF_POS    = 0;
	localparam int P_SPACING  = 10;
	localparam int P_PHASE    = 9;

	// ********************************************************************
	// cell positions of the frame fields, least significant bit first
	// ********************************************************************
	localparam int SEC_U_POS  = 1;
	localparam int SEC_T_POS  = 6;
	localparam int MIN_U_POS  = 10;
	localparam int MIN_T_POS  = 15;
	localparam int HOUR_U_POS = 20;
	localparam int HOUR_T_POS = 25;
	localparam int DAY_U_POS  = 30;
	localparam int DAY_T_POS  = 35;
	localparam int DAY_H_POS  = 40;
	localparam int YEAR_U_POS = 50;
	localparam int YEAR_T_POS = 55;
	localparam int CTRL_A_POS = 60;
	localparam int CTRL_B_POS = 70;
	localparam int SBS_A_POS  = 80;
	localparam int SBS_B_POS  = 90;

	// ********************************************************************
	// packed time word delivered by the time keeper (bcd digits)
	// ********************************************************************
	localparam int TIME_W     = 38;
	localparam int T_SEC      = 0;
	localparam int T_MIN      = 7;
	localparam int T_HOUR     = 14;
	localparam int T_DAY      = 20;
	localparam int T_YEAR     = 30;
	localparam int SBS_W      = 17;
	localparam int CTRL_W     = 18;

	// ********************************************************************
	// setup byte fields
	// ********************************************************************
	localparam int SETUP_BASE_LSB = 6;
	localparam int SETUP_INV_BIT  = 4;
	localparam logic [1:0] BASE_LOCAL = 2'h0;
	localparam logic [1:0] BASE_STD   = 2'h1;
	localparam logic [1:0] BASE_UTC   = 2'h2;
	localparam logic [2:0] FMT_B002   = 3'h0;
	localparam logic [2:0] FMT_B006   = 3'h1;
	localparam logic [2:0] FMT_B003   = 3'h2;
	localparam logic [2:0] FMT_B007   = 3'h3;
	localparam logic [2:0] FMT_IEEE   = 3'h4;
	localparam logic [2:0] FMT_AFNOR  = 3'h5;

	// ********************************************************************
	// register map (byte addresses) and reset values
	// ********************************************************************
	localparam logic [7:0] ADDR_SETUP1  = 8'h00;
	localparam logic [7:0] ADDR_SETUP2  = 8'h04;
	localparam logic [7:0] ADDR_HOLDOFF = 8'h08;
	localparam logic [7:0] ADDR_CTRL    = 8'h0c;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] SETUP_RST    = 8'h00;
	localparam logic [7:0] HOLDOFF_RST  = 8'h37;
	localparam logic [7:0] HOLDOFF_MIN  = 8'h02;
	localparam logic [7:0] HOLDOFF_INF  = 8'hff;
	localparam logic [5:0] SEC_PER_MIN  = 6'h3c;

	// ********************************************************************
	// timing
	// ********************************************************************
	localparam int CLK_HZ  = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

endpackage

module igen_cell
	import igen_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic [7:0]          setup,
	input  wire logic                load,
	input  wire logic                running,
	input  wire logic [6:0]          bit_idx,
	input  wire logic [3:0]          ms_in,
	input  wire logic                enable,
	input  wire logic [TIME_W-1:0]   local_time,
	input  wire logic [TIME_W-1:0]   std_time,
	input  wire logic [TIME_W-1:0]   utc_time,
	input  wire logic [SBS_W-1:0]    local_sbs,
	input  wire logic [SBS_W-1:0]    std_sbs,
	input  wire logic [SBS_W-1:0]    utc_sbs,
	input  wire logic [CTRL_W-1:0]   ctrl_bits,
	output logic                     line
);

	typedef struct packed {
		logic [CELLS-1:0] frame;
		logic             ena;
		logic             line;
	} igen_cell_s;

	igen_cell_s st_r;
	igen_cell_s st_nxt;

	function automatic logic [CELLS-1:0] build_frame(
		input logic [TIME_W-1:0] t,
		input logic [SBS_W-1:0]  sbs,
		input logic [CTRL_W-1:0] ctl,
		input logic [2:0]        fmt
	);
		logic [CELLS-1:0] f;
		logic             has_year;
		logic             has_sbs;
		logic             has_ctl;
		f        = '0;  // unused cells stay zero
		has_year = (fmt == FMT_B006) || (fmt == FMT_B007) || fmt[2];
		has_sbs  = (fmt == FMT_B003) || (fmt == FMT_B007) || fmt[2];
		has_ctl  = fmt[2];
		f[SEC_U_POS +: 4]  = t[T_SEC +: 4];
		f[SEC_T_POS +: 3]  = t[T_SEC+4 +: 3];
		f[MIN_U_POS +: 4]  = t[T_MIN +: 4];
		f[MIN_T_POS +: 3]  = t[T_MIN+4 +: 3];
		f[HOUR_U_POS +: 4] = t[T_HOUR +: 4];
		f[HOUR_T_POS +: 2] = t[T_HOUR+4 +: 2];
		f[DAY_U_POS +: 4]  = t[T_DAY +: 4];
		f[DAY_T_POS +: 4]  = t[T_DAY+4 +: 4];
		f[DAY_H_POS +: 2]  = t[T_DAY+8 +: 2];
		// omitted content leaves its cells at zero
		if (has_year) begin
			f[YEAR_U_POS +: 4] = t[T_YEAR +: 4];
			f[YEAR_T_POS +: 4] = t[T_YEAR+4 +: 4];
		end
		if (has_ctl) begin
			f[CTRL_A_POS +: 9] = ctl[8:0];
			f[CTRL_B_POS +: 9] = ctl[17:9];
		end
		if (has_sbs) begin
			f[SBS_A_POS +: 9] = sbs[8:0];
			f[SBS_B_POS +: 8] = sbs[16:9];
		end
		return f;
	endfunction

	logic [TIME_W-1:0] t_sel;
	logic [SBS_W-1:0]  s_sel;
	logic              is_mark;
	logic [3:0]        width;
	logic              high;

	always_comb begin
		case (setup[SETUP_BASE_LSB +: 2])  // 11 falls back to local time
			BASE_STD: begin
				t_sel = std_time;
				s_sel = std_sbs;
			end
			BASE_UTC: begin
				t_sel = utc_time;
				s_sel = utc_sbs;
			end
			default: begin
				t_sel = local_time;
				s_sel = local_sbs;
			end
		endcase
		// reference cell plus every tenth cell are identifiers
		is_mark = (bit_idx == 7'(REF_POS)) ||
			((bit_idx % 7'(P_SPACING)) == 7'(P_PHASE));
		if (is_mark) begin
			width = 4'(MARK_MS);
		end else if (st_r.frame[bit_idx]) begin
			width = 4'(ONE_MS);
		end else begin
			width = 4'(ZERO_MS);
		end
		high = ms_in < width;  // high part leads the cell

		st_nxt = st_r;
		if (load) begin
			st_nxt.frame = build_frame(t_sel, s_sel, ctrl_bits, setup[2:0]);
			st_nxt.ena   = enable;
		end
		// suppressed output rests at the idle level of the polarity
		st_nxt.line = ((running && st_r.ena) ? high : 1'b0) ^ setup[SETUP_INV_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign line = st_r.line;

endmodule

// *** igen_top.sv ***
// time code generator top: ahb-lite register slave, millisecond timing, hold-off,
// and two cell encoders
// assumes second_mark, time words and status come from logic on hclk
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

module igen_top
	import igen_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp,
	input  wire logic                second_mark,
	input  wire logic                time_valid,
	input  wire logic                gps_synced,
	input  wire logic [TIME_W-1:0]   local_time,
	input  wire logic [TIME_W-1:0]   std_time,
	input  wire logic [TIME_W-1:0]   utc_time,
	input  wire logic [SBS_W-1:0]    local_sbs,
	input  wire logic [SBS_W-1:0]    std_sbs,
	input  wire logic [SBS_W-1:0]    utc_sbs,
	input  wire logic [CTRL_W-1:0]   ctrl_bits,
	output logic                     first_timecode_output,
	output logic                     second_timecode_output
);

	localparam int MSW = $clog2(MS_CYCLES);

	// ********************************************************************
	// state
	// ********************************************************************
	typedef struct packed {
		logic [MSW-1:0] ms_cyc;
		logic [3:0]     ms_in;
		logic [6:0]     bit_idx;
		logic           running;
		logic [5:0]     sec_cnt;
		logic [7:0]     min_cnt;
		logic [7:0]     setup1;
		logic [7:0]     setup2;
		logic [7:0]     holdoff;
		logic           out2_en;
		logic           dp_write;
		logic [7:0]     dp_addr;
		logic [31:0]    rdata;
		logic           ready;
		logic           resp;
	} igen_top_s;

	igen_top_s st_r;
	igen_top_s st_nxt;

	logic       active;
	logic       addr_phase;
	logic [7:0] a_off;
	logic [7:0] wbyte;

	always_comb begin
		st_nxt = st_r;

		// ********************************************************************
		// hold-off: minutes counted while running on quartz
		// ********************************************************************
		if (gps_synced) begin
			st_nxt.sec_cnt = '0;
			st_nxt.min_cnt = '0;
		end else if (second_mark) begin
			if (st_r.sec_cnt == SEC_PER_MIN - 6'h01) begin
				st_nxt.sec_cnt = '0;
				if (st_r.min_cnt != HOLDOFF_INF) begin
					st_nxt.min_cnt = st_r.min_cnt + 8'h01;
				end
			end else begin
				st_nxt.sec_cnt = st_r.sec_cnt + 6'h01;
			end
		end
		// output stops once the counted quartz minutes reach the hold-off, unless the hold-off is HOLDOFF_INF
		active = time_valid && (gps_synced ||
			(st_r.holdoff == HOLDOFF_INF) ||
			(st_r.min_cnt < st_r.holdoff));

		// ********************************************************************
		// millisecond tick and cell counters, restarted on the second mark
		// ********************************************************************
		if (second_mark) begin
			st_nxt.ms_cyc  = '0;  // tick aligned to the second
			st_nxt.ms_in   = '0;
			st_nxt.bit_idx = '0;
			st_nxt.running = 1'b1;  // one frame per second
		end else if (st_r.ms_cyc == MSW'(MS_CYCLES - 1)) begin
			st_nxt.ms_cyc = '0;
			if (st_r.ms_in == 4'(CELL_MS - 1)) begin
				st_nxt.ms_in = '0;
				if (st_r.bit_idx == 7'(CELLS - 1)) begin
					// a missing second mark stops the line rather than repeat stale time
					st_nxt.running = 1'b0;
				end else begin
					st_nxt.bit_idx = st_r.bit_idx + 7'h01;
				end
			end else begin
				st_nxt.ms_in = st_r.ms_in + 4'h1;
			end
		end else begin
			st_nxt.ms_cyc = st_r.ms_cyc + MSW'(1);
		end

		// ********************************************************************
		// ahb-lite slave, zero wait states
		// ********************************************************************
		addr_phase = hsel && hready && htrans[1];
		a_off      = haddr[7:0];
		wbyte      = hwdata[7:0];
		st_nxt.ready = 1'b1;
		st_nxt.resp  = 1'b0;
		if (st_r.dp_write) begin
			case (st_r.dp_addr)
				ADDR_SETUP1: begin
					st_nxt.setup1 = wbyte;
				end
				ADDR_SETUP2: begin
					st_nxt.setup2 = wbyte;
				end
				ADDR_HOLDOFF: begin
					// values below the minimum are raised to it
					st_nxt.holdoff = (wbyte < HOLDOFF_MIN) ? HOLDOFF_MIN : wbyte;
				end
				ADDR_CTRL: begin
					st_nxt.out2_en = hwdata[0];
				end
				default: begin
				end
			endcase
		end
		st_nxt.dp_write = addr_phase && hwrite;
		st_nxt.dp_addr  = a_off;
		if (addr_phase && !hwrite) begin
			// read data registered here so hrdata is a flop in the data phase
			case ({a_off[7:2], 2'h0})
				ADDR_SETUP1: begin
					st_nxt.rdata = {24'h000000, st_r.setup1};
				end
				ADDR_SETUP2: begin
					st_nxt.rdata = {24'h000000, st_r.setup2};
				end
				ADDR_HOLDOFF: begin
					st_nxt.rdata = {24'h000000, st_r.holdoff};
				end
				ADDR_CTRL: begin
					st_nxt.rdata = {31'h00000000, st_r.out2_en};
				end
				ADDR_STATUS: begin
					st_nxt.rdata = {16'h0000, st_r.min_cnt, 4'h0, time_valid,
						gps_synced, active && st_r.out2_en, active};
				end
				default: begin
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end else begin
			st_nxt.rdata = 32'h00000000;
		end
		// the write decode ignores the two low address bits, as the read decode does
		if (addr_phase && hwrite) begin
			st_nxt.dp_addr = {a_off[7:2], 2'h0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r         <= '0;
			st_r.setup1  <= SETUP_RST;
			st_r.setup2  <= SETUP_RST;
			st_r.holdoff <= HOLDOFF_RST;
			st_r.ready   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hreadyout = st_r.ready;
	assign hrdata    = st_r.rdata;
	assign hresp     = st_r.resp;

	// ********************************************************************
	// cell encoders
	// ********************************************************************
	igen_cell u_out1 (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.setup      (st_r.setup1),
		.load       (second_mark),
		.running    (st_r.running),
		.bit_idx    (st_r.bit_idx),
		.ms_in      (st_r.ms_in),
		.enable     (active),
		.local_time (local_time),
		.std_time   (std_time),
		.utc_time   (utc_time),
		.local_sbs  (local_sbs),
		.std_sbs    (std_sbs),
		.utc_sbs    (utc_sbs),
		.ctrl_bits  (ctrl_bits),
		.line       (first_timecode_output)
	);

	// same encoder and hold-off, gated by its own enable
	igen_cell u_out2 (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.setup      (st_r.setup2),
		.load       (second_mark),
		.running    (st_r.running),
		.bit_idx    (st_r.bit_idx),
		.ms_in      (st_r.ms_in),
		.enable     (active && st_r.out2_en),
		.local_time (local_time),
		.std_time   (std_time),
		.utc_time   (utc_time),
		.local_sbs  (local_sbs),
		.std_sbs    (std_sbs),
		.utc_sbs    (utc_sbs),
		.ctrl_bits  (ctrl_bits),
		.line       (second_timecode_output)
	);

endmodule

// *** igen_top_properties.sv ***
// port checker of the time code generator
// assumes one hclk domain and a bind to every igen_top
`timescale 1ns/1ns
module igen_top_properties
	import igen_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        second_mark,
	input wire logic        time_valid,
	input wire logic        first_timecode_output,
	input wire logic        second_timecode_output
);
	localparam int D2   = 2 * MS_CYCLES;
	localparam int D5   = 5 * MS_CYCLES;
	localparam int D8   = 8 * MS_CYCLES;
	localparam int D7   = D8 - 1;
	localparam int CELL = CELL_MS * MS_CYCLES;
	localparam int FEND = 3 + CELLS * CELL;
	logic       wph, inv1, inv2, i1q, i2q, en2, en2f, dead;
	logic [7:0] wa;
	int         since, hi1, hi2;
	// polarity is tracked one cycle late because the line itself is registered
	wire        l1 = first_timecode_output ^ i1q;
	wire        l2 = second_timecode_output ^ i2q;

	// ********
	// shadow of setup, enable and frame phase
	// ********
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph <= 1'b0;
			wa <= 8'h00;
			{inv1, inv2, i1q, i2q, en2, en2f, dead} <= 7'h00;
			since <= FEND + 10;
			hi1 <= 0;
			hi2 <= 0;
		end else begin
			wph <= hsel && hready && htrans[1] && hwrite;
			wa <= haddr[7:0];
			if (wph && wa == ADDR_SETUP1) inv1 <= hwdata[SETUP_INV_BIT];
			if (wph && wa == ADDR_SETUP2) inv2 <= hwdata[SETUP_INV_BIT];
			if (wph && wa == ADDR_CTRL) en2 <= hwdata[0];
			i1q <= inv1;
			i2q <= inv2;
			if (second_mark) begin
				en2f <= en2;
				dead <= !time_valid;
				since <= 1;
			end else if (since < FEND + 10) begin
				since <= since + 1;
			end
			hi1 <= l1 ? hi1 + 1 : 0;
			hi2 <= l2 ? hi2 + 1 : 0;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_ready_high: assert property (hreadyout) else $error("wait state seen");
	a_resp_okay: assert property (!hresp) else $error("error response seen");
	a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |->
		hrdata == 32'h0) else $error("read data outside data phase");
	a_pulse_width: assert property (
		$fell(l1) && since > 3 && since <= FEND |-> hi1 == D2 || hi1 == D5 || hi1 == D8)
		else $error("bad high width on first line");
	a_cell_start: assert property (
		$rose(l1) && since > 3 && since <= FEND |-> (since - 2) % CELL == 0)
		else $error("cell starts off the cell grid");
	a_frame_lead: assert property (
		since == 2 && l1 |-> ##D7 l1 ##1 !l1) else $error("frame lead is not an identifier");
	a_tail_idle: assert property (
		since > FEND |-> !l1) else $error("line active after last cell");
	a_dead_frame: assert property (
		dead && since > 2 |-> !l1) else $error("frame sent without valid time");
	a_second_off: assert property (
		!en2f && since > 2 |-> !l2) else $error("disabled second line active");
	a_second_width: assert property (
		$fell(l2) && since > 3 && since <= FEND |-> hi2 == D2 || hi2 == D5 || hi2 == D8)
		else $error("bad high width on second line");
endmodule

bind igen_top igen_top_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.second_mark(second_mark), .time_valid(time_valid),
	.first_timecode_output(first_timecode_output),
	.second_timecode_output(second_timecode_output));

// *** igen_rx.sv ***
// receiver model: decodes high widths of one time code line into symbols
// assumes the line and its polarity change only on hclk
`timescale 1ns/1ns
module igen_rx #(
	parameter int MS = 2
)
(
	input wire logic hclk,
	input wire logic line,
	input wire logic inv
);
	int hi = 0;
	int q[$];

	// ********
	// width decoder: 0, 1, identifier 2, anything else 3
	// ********
	always @(posedge hclk) begin
		if (line ^ inv) begin
			hi <= hi + 1;
		end else begin
			if (hi > 0) q.push_back(hi == 2 * MS ? 0 : hi == 5 * MS ? 1 : hi == 8 * MS ? 2 : 3);
			hi <= 0;
		end
	end
endmodule

// *** igen_top_tb_top.sv ***
// testbench of the time code generator: bus tasks, frames decoded by igen_rx
// assumes igen_top with a shortened millisecond count
`timescale 1ns/1ns
module igen_top_tb_top
	import igen_pkg::*;
;
	localparam int MS    = 2;
	localparam int FRAME = CELLS * CELL_MS * MS;
	logic              hclk = 0, hresetn = 0, hwrite = 0, second_mark = 0;
	logic              time_valid = 1, gps_synced = 1, use2 = 0, inv = 0;
	logic [1:0]        htrans = 0;
	logic [31:0]       haddr = 0, hwdata = 0, rd;
	logic [TIME_W-1:0] lt = 0, st = 0, ut = 0;
	logic [SBS_W-1:0]  ls = 0, ss = 0, us = 0;
	logic [CTRL_W-1:0] cb = 0;
	logic [72:0]       w;
	wire               hreadyout, hresp, o1, o2;
	wire [31:0]        hrdata;
	wire               rx_line = use2 ? o2 : o1;
	int                errors = 0, samples_checked = 0;
	int                ex[CELLS];

	igen_top #(.MS_CYCLES(MS)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .second_mark(second_mark),
		.time_valid(time_valid), .gps_synced(gps_synced), .local_time(lt), .std_time(st),
		.utc_time(ut), .local_sbs(ls), .std_sbs(ss), .utc_sbs(us), .ctrl_bits(cb),
		.first_timecode_output(o1), .second_timecode_output(o2));
	igen_rx #(.MS(MS)) rx (.hclk(hclk), .line(rx_line), .inv(inv));

	initial forever #5 hclk = ~hclk;

	// ********
	// tasks
	// ********
	task automatic results();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			errors++;
			results();
		end
	endtask
	task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge hclk);
		hwrite <= wr;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		rd = hrdata;
	endtask
	function automatic logic [TIME_W-1:0] randt();
		return {4'($urandom_range(9)), 4'($urandom_range(9)), 2'($urandom_range(2)),
			4'($urandom_range(9)), 4'($urandom_range(9)), 2'($urandom_range(1)),
			4'($urandom_range(9)), 3'($urandom_range(5)), 4'($urandom_range(9)),
			3'($urandom_range(5)), 4'($urandom_range(9))};
	endfunction
	task automatic put(int pos, int n, int lsb);
		for (int i = 0; i < n; i++) ex[pos + i] = w[lsb + i];
	endtask
	task automatic build(logic [2:0] f);
		for (int i = 0; i < CELLS; i++) ex[i] = (i == REF_POS || i % P_SPACING == P_PHASE) ? 2 : 0;
		put(1, 4, 0); put(6, 3, 4); put(10, 4, 7); put(15, 3, 11); put(20, 4, 14);
		put(25, 2, 18); put(30, 4, 20); put(35, 4, 24); put(40, 2, 28);
		if (f[2] | f[0]) begin
			put(50, 4, 30); put(55, 4, 34);
		end
		if (f[2]) begin
			put(60, 9, 55); put(70, 9, 64);
		end
		if (f[2] | f[1]) begin
			put(80, 9, 38); put(90, 8, 47);
		end
	endtask
	// one setup write, one second mark, then n decoded cells are expected
	task automatic frame(logic [7:0] a, logic [7:0] cfg, int n);
		xfer(1'b1, a, {24'h0, cfg});
		inv <= cfg[SETUP_INV_BIT];
		{lt, st, ut} <= {randt(), randt(), randt()};
		ls <= 17'($urandom_range(86399));
		ss <= 17'($urandom_range(86399));
		us <= 17'($urandom_range(86399));
		cb <= 18'($urandom);
		// settle time lets a polarity change leave the decoder before it is flushed
		repeat (3) @(posedge hclk);
		case (cfg[7:6])
			BASE_STD: w = {cb, ss, st};
			BASE_UTC: w = {cb, us, ut};
			default: w = {cb, ls, lt};
		endcase
		build(cfg[2:0]);
		second_mark <= 1'b1;
		rx.q.delete();
		@(posedge hclk);
		second_mark <= 1'b0;
		repeat (FRAME + 10) @(posedge hclk);
		chk(rx.q.size(), n);
		for (int i = 0; i < n && i < rx.q.size(); i++) chk(rx.q[i], ex[i]);
	endtask

	// ********
	// sequence
	// ********
	initial begin
		repeat (100000) @(posedge hclk);
		errors++;
		results();
	end
	initial begin
		void'($urandom(30808));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, ADDR_HOLDOFF, 32'h0);
		chk(rd, {24'h0, HOLDOFF_RST});
		xfer(1'b0, ADDR_SETUP1, 32'h0);
		chk(rd, {24'h0, SETUP_RST});
		xfer(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b1, ADDR_HOLDOFF, 32'h1);
		xfer(1'b0, ADDR_HOLDOFF, 32'h0);
		chk(rd, {24'h0, HOLDOFF_MIN});
		for (int f = 0; f < 8; f++) frame(ADDR_SETUP1, {2'($urandom_range(3)), 3'h0, 3'(f)}, CELLS);
		frame(ADDR_SETUP1, {BASE_UTC, 3'h2, FMT_IEEE}, CELLS);
		xfer(1'b1, ADDR_CTRL, 32'h1);
		use2 <= 1'b1;
		frame(ADDR_SETUP2, {BASE_STD, 3'h2, FMT_B007}, CELLS);
		use2 <= 1'b0;
		xfer(1'b1, ADDR_CTRL, 32'h0);
		gps_synced <= 1'b0;
		// marks every 20 cycles: more than two minutes on quartz in a short run
		repeat (125) begin
			@(posedge hclk);
			second_mark <= 1'b1;
			@(posedge hclk);
			second_mark <= 1'b0;
			repeat (18) @(posedge hclk);
		end
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk({20'h0, rd[15:8], rd[3:0]}, 32'h28);
		frame(ADDR_SETUP1, {BASE_LOCAL, 3'h0, FMT_B003}, 0);
		xfer(1'b1, ADDR_HOLDOFF, {24'h0, HOLDOFF_INF});
		frame(ADDR_SETUP1, {BASE_LOCAL, 3'h0, FMT_AFNOR}, CELLS);
		time_valid <= 1'b0;
		frame(ADDR_SETUP1, {BASE_UTC, 3'h0, FMT_B002}, 0);
		results();
	end
endmodule
